//--- logic/dbs_pkg.sv
// Purpose: constants for the display bring-up sequencer register block
// Assumes: apb slave, 32-bit data, pclk at 100 MHz
// Notes:   settle delays model power and port buffer targets reaching their state
package dbs_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_POWER_CTL  = 8'h00;  // power requests
    localparam logic [7:0] OFF_POWER_STS  = 8'h04;  // power states, read only
    localparam logic [7:0] OFF_LINK_CTL   = 8'h08;  // link transport control
    localparam logic [7:0] OFF_LINK_STS   = 8'h0C;  // link transport status
    localparam logic [7:0] OFF_PORT_CTL   = 8'h10;  // port buffer control
    localparam logic [7:0] OFF_XCODER_CTL = 8'h14;  // transcoder function control
    // power control / status bit positions
    localparam int BIT_SLICE1 = 0;
    localparam int BIT_SLICE2 = 1;
    localparam int BIT_DOM1   = 2;
    localparam int BIT_PORTIO = 3;
    localparam int NUM_PWR    = 4;
    // link control fields
    localparam int BIT_LINK_EN = 0;
    localparam int LSB_PAT     = 1;
    localparam int W_PAT       = 2;
    localparam int LSB_SWING   = 3;
    localparam int W_SWING     = 4;
    // link status bits
    localparam int BIT_IDLES_SENT = 0;
    localparam int BIT_ALLOC_SENT = 1;
    // port buffer bits
    localparam int BIT_BUF_EN   = 0;
    localparam int BIT_BUF_IDLE = 1;
    // transcoder control bits
    localparam int BIT_ALLOC_EN = 0;
    // training patterns
    localparam logic [1:0] PAT_TRAIN1 = 2'h0;
    localparam logic [1:0] PAT_IDLE   = 2'h2;
    localparam logic [1:0] PAT_NORMAL = 2'h3;
    // timing
    localparam int CLK_MHZ        = 100;
    localparam int PWR_SETTLE_NS  = 2000;
    localparam int PWR_SETTLE_CYC = PWR_SETTLE_NS * CLK_MHZ / 1000;
    localparam int BUF_WAKE_NS    = 1000;
    localparam int BUF_WAKE_CYC   = BUF_WAKE_NS * CLK_MHZ / 1000;
    localparam int IDLE_PAT_CYC   = 40;  // cycles per idle pattern
    localparam int IDLES_NEEDED   = 5;
    localparam int ALLOC_CYC      = 64;  // allocation trigger send time
    localparam int CNT_W          = 16;
endpackage

//--- logic/dbs_sequencer.sv
// Purpose: register block and status handshakes of the display bring-up sequencer
// Assumes: software keeps the documented enable/disable order and timeouts
// Notes:   power targets settle after a fixed delay; status follows only then
//
// Summary of operation
// - slice power state reads one only after its request has settled
// - clearing slice requests drops state to zero; software fails after 10 us
// - port IO power request reports enabled; software times out at 20 us
// - enabled port buffer drops idle status; software fails after 500 us
// - idle pattern flags five idles sent; software times out after 800 us
// - payload allocation enable reports trigger sent; wait over 410 us
// - swing changes accepted while port stays enabled
// - first domain request reports state one; software fails after 10 us
module dbs_sequencer (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // controls and power state toward the engine
    output logic      [3:0]  power_req,
    output logic      [3:0]  power_state,
    output logic      [1:0]  link_pattern,
    output logic      [3:0]  link_swing,
    output logic             port_buffer_en
);
    localparam int NP = dbs_pkg::NUM_PWR;

    // apb decode: zero wait state
    logic wr_en;
    logic rd_hit;
    assign wr_en   = psel & penable & pwrite;
    assign pready  = 1'b1;
    assign rd_hit  = (paddr == dbs_pkg::OFF_POWER_CTL) | (paddr == dbs_pkg::OFF_POWER_STS) |
                     (paddr == dbs_pkg::OFF_LINK_CTL)  | (paddr == dbs_pkg::OFF_LINK_STS)  |
                     (paddr == dbs_pkg::OFF_PORT_CTL)  | (paddr == dbs_pkg::OFF_XCODER_CTL);
    assign pslverr = psel & penable & ~rd_hit;

    function automatic logic wr_to(input logic [7:0] off);
        return wr_en && (paddr == off);
    endfunction

    // software-written control registers
    logic [NP-1:0] pwr_req_ff;
    logic          link_en_ff;
    logic [1:0]    pat_ff;
    logic [3:0]    swing_ff;
    logic          buf_en_ff;
    logic          alloc_en_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_req_ff  <= '0;
            link_en_ff  <= 1'b0;
            pat_ff      <= dbs_pkg::PAT_TRAIN1;
            swing_ff    <= '0;
            buf_en_ff   <= 1'b0;
            alloc_en_ff <= 1'b0;
        end else begin
            if (wr_to(dbs_pkg::OFF_POWER_CTL)) begin
                pwr_req_ff <= pwdata[NP-1:0];
            end
            if (wr_to(dbs_pkg::OFF_LINK_CTL)) begin
                link_en_ff <= pwdata[dbs_pkg::BIT_LINK_EN];
                pat_ff     <= pwdata[dbs_pkg::LSB_PAT +: dbs_pkg::W_PAT];
                swing_ff   <= pwdata[dbs_pkg::LSB_SWING +: dbs_pkg::W_SWING];  // no port disable needed
            end
            if (wr_to(dbs_pkg::OFF_PORT_CTL)) begin
                buf_en_ff <= pwdata[dbs_pkg::BIT_BUF_EN];
            end
            if (wr_to(dbs_pkg::OFF_XCODER_CTL)) begin
                alloc_en_ff <= pwdata[dbs_pkg::BIT_ALLOC_EN];
            end
        end
    end

    // per-domain settle counters: state follows request only after settling
    logic [NP-1:0]             pwr_state_ff;
    logic [NP-1:0]             pwr_differs;
    logic [dbs_pkg::CNT_W-1:0] settle_ff [NP];
    assign pwr_differs = pwr_req_ff ^ pwr_state_ff;
    // one process for all domains, so the state vector has a single writer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NP; i++) begin
                settle_ff[i] <= '0;
            end
            pwr_state_ff <= '0;
        end else begin
            for (int i = 0; i < NP; i++) begin
                if (!pwr_differs[i]) begin
                    settle_ff[i] <= '0;
                end else if (settle_ff[i] == dbs_pkg::CNT_W'(dbs_pkg::PWR_SETTLE_CYC - 1)) begin
                    settle_ff[i]    <= '0;
                    pwr_state_ff[i] <= pwr_req_ff[i];
                end else begin
                    settle_ff[i] <= settle_ff[i] + 1'b1;
                end
            end
        end
    end

    // port buffer idle status: leaves idle after wake time, returns on disable
    logic                      buf_idle_ff;
    logic [dbs_pkg::CNT_W-1:0] wake_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_idle_ff <= 1'b1;
            wake_ff     <= '0;
        end else if (!buf_en_ff) begin
            buf_idle_ff <= 1'b1;
            wake_ff     <= '0;
        end else if (buf_idle_ff) begin
            if (wake_ff == dbs_pkg::CNT_W'(dbs_pkg::BUF_WAKE_CYC - 1)) begin
                buf_idle_ff <= 1'b0;
            end else begin
                wake_ff <= wake_ff + 1'b1;
            end
        end
    end

    // idle pattern counter: flag after five idle patterns on an enabled link
    logic                      idles_sent_ff;
    logic [dbs_pkg::CNT_W-1:0] pat_cyc_ff;
    logic [2:0]                idle_cnt_ff;
    logic                      sending_idle;
    assign sending_idle = link_en_ff & ~buf_idle_ff & (pat_ff == dbs_pkg::PAT_IDLE);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idles_sent_ff <= 1'b0;
            pat_cyc_ff    <= '0;
            idle_cnt_ff   <= '0;
        end else if (!sending_idle) begin
            idles_sent_ff <= 1'b0;
            pat_cyc_ff    <= '0;
            idle_cnt_ff   <= '0;
        end else if (pat_cyc_ff == dbs_pkg::CNT_W'(dbs_pkg::IDLE_PAT_CYC - 1)) begin
            pat_cyc_ff <= '0;
            if (idle_cnt_ff == 3'(dbs_pkg::IDLES_NEEDED - 1)) begin
                idles_sent_ff <= 1'b1;
            end else begin
                idle_cnt_ff <= idle_cnt_ff + 1'b1;
            end
        end else begin
            pat_cyc_ff <= pat_cyc_ff + 1'b1;
        end
    end

    // allocation change trigger: sent some time after each allocation change
    logic                      alloc_sent_ff;
    logic                      alloc_prev_ff;
    logic [dbs_pkg::CNT_W-1:0] alloc_cnt_ff;
    logic                      alloc_busy_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alloc_sent_ff <= 1'b0;
            alloc_prev_ff <= 1'b0;
            alloc_cnt_ff  <= '0;
            alloc_busy_ff <= 1'b0;
        end else begin
            alloc_prev_ff <= alloc_en_ff;
            if (alloc_en_ff != alloc_prev_ff) begin
                alloc_busy_ff <= 1'b1;
                alloc_sent_ff <= 1'b0;
                alloc_cnt_ff  <= '0;
            end else if (alloc_busy_ff) begin
                if (alloc_cnt_ff == dbs_pkg::CNT_W'(dbs_pkg::ALLOC_CYC - 1)) begin
                    alloc_busy_ff <= 1'b0;
                    alloc_sent_ff <= 1'b1;
                end else begin
                    alloc_cnt_ff <= alloc_cnt_ff + 1'b1;
                end
            end
        end
    end

    // read mux
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        unique case (paddr)
            dbs_pkg::OFF_POWER_CTL:  rd_mux[NP-1:0] = pwr_req_ff;
            dbs_pkg::OFF_POWER_STS:  rd_mux[NP-1:0] = pwr_state_ff;
            dbs_pkg::OFF_LINK_CTL: begin
                rd_mux[dbs_pkg::BIT_LINK_EN]                      = link_en_ff;
                rd_mux[dbs_pkg::LSB_PAT +: dbs_pkg::W_PAT]        = pat_ff;
                rd_mux[dbs_pkg::LSB_SWING +: dbs_pkg::W_SWING]    = swing_ff;
            end
            dbs_pkg::OFF_LINK_STS: begin
                rd_mux[dbs_pkg::BIT_IDLES_SENT] = idles_sent_ff;
                rd_mux[dbs_pkg::BIT_ALLOC_SENT] = alloc_sent_ff;
            end
            dbs_pkg::OFF_PORT_CTL: begin
                rd_mux[dbs_pkg::BIT_BUF_EN]   = buf_en_ff;
                rd_mux[dbs_pkg::BIT_BUF_IDLE] = buf_idle_ff;
            end
            dbs_pkg::OFF_XCODER_CTL: rd_mux[dbs_pkg::BIT_ALLOC_EN] = alloc_en_ff;
            default:                 rd_mux = 32'h0;
        endcase
    end
    // read data registered during setup so it is stable in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel & ~penable & ~pwrite) begin
            prdata <= rd_mux;
        end
    end

    // outputs
    assign power_req      = pwr_req_ff;
    assign power_state    = pwr_state_ff;
    assign link_pattern   = pat_ff;
    assign link_swing     = swing_ff;
    assign port_buffer_en = buf_en_ff;

    // assertions
    localparam int DOM_ON_LIMIT = 1000;  // software gives up after 10 us at 100 MHz
    // first domain freshly requested from off, then held for eight cycles
    sequence dom_req_held_s;
        $rose(pwr_req_ff[dbs_pkg::BIT_DOM1]) && !pwr_state_ff[dbs_pkg::BIT_DOM1]
            ##1 pwr_req_ff[dbs_pkg::BIT_DOM1] [*8];
    endsequence
    state_after_req_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(pwr_state_ff[0]) |-> $past(pwr_req_ff[0], dbs_pkg::PWR_SETTLE_CYC))
        else $error("slice state rose without settled request");
    state_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(pwr_state_ff[1]) |-> $past(!pwr_req_ff[1], dbs_pkg::PWR_SETTLE_CYC))
        else $error("slice state fell while requested");
    dom_state_a: assert property (@(posedge pclk) disable iff (!presetn)
        dom_req_held_s |-> !pwr_state_ff[dbs_pkg::BIT_DOM1])
        else $error("domain state rose too early");
    dom_on_time_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(pwr_req_ff[dbs_pkg::BIT_DOM1]) |-> ##[1:DOM_ON_LIMIT]
            (pwr_state_ff[dbs_pkg::BIT_DOM1] || !pwr_req_ff[dbs_pkg::BIT_DOM1]))
        else $error("domain state not reported in time");
    portio_state_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(pwr_state_ff[3]) |-> $past(pwr_req_ff[3], dbs_pkg::PWR_SETTLE_CYC))
        else $error("port io state without request");
    buf_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        !buf_en_ff |=> buf_idle_ff)
        else $error("buffer not idle while disabled");
    idles_sent_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(idles_sent_ff) |-> sending_idle && $past(sending_idle, dbs_pkg::IDLES_NEEDED * dbs_pkg::IDLE_PAT_CYC))
        else $error("idles flagged too early");
    alloc_sent_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(alloc_sent_ff) |-> alloc_en_ff == $past(alloc_en_ff, dbs_pkg::ALLOC_CYC))
        else $error("allocation trigger without change");
    swing_live_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && (paddr == dbs_pkg::OFF_LINK_CTL) && buf_en_ff |=>
            buf_en_ff && swing_ff == $past(pwdata[dbs_pkg::LSB_SWING +: dbs_pkg::W_SWING]))
        else $error("swing change lost or port dropped");
    pair_a: assert property (@(posedge pclk) disable iff (!presetn)
        pwr_req_ff == pwr_state_ff |=> settle_ff[0] == '0)
        else $error("settle counter runs with no change");
endmodule

//--- dv/dbs_sw_model.sv
// Purpose: driver-software model: apb master with read, write and bounded poll
// Assumes: slave answers whenever pready is high; no wait count is assumed
// Notes:   every poll gives up at its software timeout, so a stuck status bit
//          shows up as a failed poll instead of a hang
module dbs_sw_model (
    // clock
    input  wire logic        pclk,
    // apb master side
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [7:0]  paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ps;

    // bus idle from time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
    end

    // one transfer; the leading edge keeps a release and a new setup apart
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q       = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // poll one status bit until it reads v, failing after lim_ns
    task automatic poll(input logic [7:0] a, input int b, input logic v, input int lim_ns,
                        output logic ok);
        logic [31:0] q;
        logic        e;
        time         t0;
        ok = 1'b0;
        t0 = $time;
        while (!ok && ($time - t0) <= lim_ns) begin
            xfer(1'b0, a, 32'h0, q, e);
            ok = (q[b] === v);
        end
    endtask
endmodule

//--- dv/tb_top.sv
// Purpose: self-checking bench of the bring-up sequencer register block
// Assumes: zero-wait apb slave, settle delays far below software timeouts
// Notes:   the bring-up and teardown follow the software order end to end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  power_req;
    logic [3:0]  power_state;
    logic [1:0]  link_pattern;
    logic [3:0]  link_swing;
    logic        port_buffer_en;
    logic [31:0] q;
    logic        e;
    logic        ok;
    int          mismatches;
    int          n_checks;

    typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} dbs_row_s;
    // write, then read back: rw masks, read-only bits and unmapped places
    dbs_row_s rows [7] = '{'{8'h08, 32'hFFFFFFFF, 32'h7F, 1'b0}, '{8'h08, 32'h0, 32'h0, 1'b0},
        '{8'h14, 32'hFFFFFFFF, 32'h1, 1'b0}, '{8'h14, 32'h0, 32'h0, 1'b0},
        '{8'h04, 32'hF, 32'h0, 1'b0}, '{8'h10, 32'h2, 32'h2, 1'b0}, '{8'h18, 32'hFFFFFFFF, 32'h0, 1'b1}};

    dbs_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .power_req(power_req), .power_state(power_state), .link_pattern(link_pattern),
        .link_swing(link_swing), .port_buffer_en(port_buffer_en));

    dbs_sw_model sw (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        sw.xfer(1'b1, a, d, q, e);
        @(negedge pclk);  // the write lands at the access edge; outputs are settled only after it
    endtask

    // link control word with the enable set
    function automatic logic [31:0] lnk(input logic [1:0] p, input logic [3:0] s);
        return {25'h0, s, p, 1'b1};
    endfunction

    task automatic end_sim();
        if (mismatches == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // hang guard, well past the whole sequence
    initial begin
        #900000;
        mismatches++;
        end_sim();
    end

    initial begin
        mismatches = 0;
        n_checks   = 0;
        presetn    = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        // reset values: only the buffer idle bit reads one
        for (int i = 0; i < 6; i++) begin
            sw.xfer(1'b0, 8'(i * 4), 32'h0, q, e);
            chk(q, (i == 4) ? 32'h2 : 32'h0);
        end
        chk({17'h0, power_req, power_state, link_pattern, link_swing, port_buffer_en}, 32'h0);
        chk({31'h0, pready}, 32'h1);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            chk({31'h0, e}, {31'h0, rows[i].e});
            sw.xfer(1'b0, rows[i].a, 32'h0, q, e);
            chk(q, rows[i].q);
        end
        // slice power: state must not run ahead of its request
        wr(8'h00, 32'h1);
        sw.xfer(1'b0, 8'h04, 32'h0, q, e);
        chk(q, 32'h0);
        chk({28'h0, power_req}, 32'h1);
        sw.poll(8'h04, dbs_pkg::BIT_SLICE1, 1'b1, 10000, ok);
        chk({31'h0, ok}, 32'h1);
        wr(8'h00, 32'h7);  // second slice joins with the first domain
        sw.poll(8'h04, dbs_pkg::BIT_DOM1, 1'b1, 10000, ok);
        chk({31'h0, ok}, 32'h1);
        wr(8'h00, 32'hF);  // port IO power comes up before any port
        sw.poll(8'h04, dbs_pkg::BIT_PORTIO, 1'b1, 20000, ok);
        chk({31'h0, ok}, 32'h1);
        // training: pattern one first, then swing, then buffer
        wr(8'h08, lnk(dbs_pkg::PAT_TRAIN1, 4'h0));
        wr(8'h08, lnk(dbs_pkg::PAT_TRAIN1, 4'h5));
        wr(8'h10, 32'h1);
        sw.poll(8'h10, dbs_pkg::BIT_BUF_IDLE, 1'b0, 500000, ok);
        chk({31'h0, ok}, 32'h1);
        wr(8'h08, lnk(dbs_pkg::PAT_TRAIN1, 4'hA));
        chk({27'h0, port_buffer_en, link_swing}, 32'h1A);
        sw.xfer(1'b0, 8'h10, 32'h0, q, e);
        chk(q, 32'h1);
        // lane or rate change: port off, back to idle, then retrain from pattern one
        wr(8'h10, 32'h0);
        sw.xfer(1'b0, 8'h10, 32'h0, q, e);
        chk(q, 32'h2);
        wr(8'h08, lnk(dbs_pkg::PAT_TRAIN1, 4'hA));
        wr(8'h10, 32'h1);
        sw.poll(8'h10, dbs_pkg::BIT_BUF_IDLE, 1'b0, 500000, ok);
        chk({31'h0, ok}, 32'h1);
        wr(8'h08, lnk(dbs_pkg::PAT_IDLE, 4'hA));
        sw.poll(8'h0C, dbs_pkg::BIT_IDLES_SENT, 1'b1, 800000, ok);
        chk({31'h0, ok}, 32'h1);
        wr(8'h08, lnk(dbs_pkg::PAT_NORMAL, 4'hA));
        chk({30'h0, link_pattern}, {30'h0, dbs_pkg::PAT_NORMAL});
        // refresh limits, sync select, shadow updates, joiner pipes and slave-first order sit in
        // registers outside this block; software comes here only after them
        wr(8'h14, 32'h1);
        sw.poll(8'h0C, dbs_pkg::BIT_ALLOC_SENT, 1'b1, 500000, ok);
        chk({31'h0, ok}, 32'h1);
        // teardown toward the deepest state, in disable order
        wr(8'h14, 32'h0);
        wr(8'h10, 32'h0);
        wr(8'h08, 32'h0);
        wr(8'h00, 32'h4);
        sw.poll(8'h04, dbs_pkg::BIT_SLICE1, 1'b0, 10000, ok);
        chk({31'h0, ok}, 32'h1);
        sw.poll(8'h04, dbs_pkg::BIT_SLICE2, 1'b0, 10000, ok);
        chk({31'h0, ok}, 32'h1);
        sw.xfer(1'b0, 8'h04, 32'h0, q, e);
        chk(q, 32'h4);
        wr(8'h00, 32'h0);
        // fixed wait, no polling of the first domain
        repeat (1000) @(posedge pclk);
        sw.xfer(1'b0, 8'h04, 32'h0, q, e);
        chk(q, 32'h0);
        end_sim();
    end
endmodule
